/* design/apr_pkg.sv */
package apr_pkg;
  // command codes of the two setup words
  localparam logic [7:0] CMD_PIN_ONE = 8'hD5;
  localparam logic [7:0] CMD_PIN_TWO = 8'hD6;
  // reset values
  localparam logic [15:0] PIN_ONE_RST = 16'h0000;
  localparam logic [15:0] PIN_TWO_RST = 16'h8000;
  // bit 2 of the second word is reserved and reads zero
  localparam logic [15:0] PIN_TWO_WMASK = 16'hFFFB;
  // field positions
  localparam int EN_HI = 15;
  localparam int EN_LO = 4;
  localparam int POL_BIT = 3;
  localparam int CONV_BIT = 2;
  localparam int PLAIN_BIT = 1;
  localparam int LEVEL_BIT = 0;
  localparam int NUM_FLAGS = 12;

  // status flags, first field sits at enable bit 15
  typedef struct packed {
    logic pass_transistor_degraded;
    logic output_overcurrent_fault;
    logic input_overvoltage_fault;
    logic input_undervoltage_fault;
    logic communication_error_flag;
    logic output_overcurrent_warning;
    logic second_current_warning;
    logic input_overvoltage_warning;
    logic input_undervoltage_warning;
    logic output_overvoltage_warning;
    logic output_undervoltage_warning;
    logic inrush_limit_active;
  } apr_flags_t;

  // word request from the bus interface, link domain
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } apr_lreq_t;

  // answer to the bus interface, link domain
  typedef struct packed {
    logic ack;
    logic nack;
    logic rvalid;
    logic [15:0] rdata;
  } apr_lans_t;

  // one pin driver: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } apr_pin_t;
endpackage : apr_pkg

/* design/apr_top.sv */
`timescale 1ns/1ns
// Notes on behaviour
// [R1] pin one word at 0xD5, resets 0x0000
// [R2] pin two word at 0xD6, resets 0x8000
// [R3] pin one bits 15..11 enable fault alerts
// [R4] pin one bits 10..4 enable warning alerts
// [R5] enabled set flag asserts that pin's alert
// [R6] pin one bit 3 sets alert polarity
// [R7] pin one bit 2 makes conversion trigger input
// [R8] pin one bit 1 selects plain output
// [R9] pin one bit 0 sets plain output level
// [R10] pin two bits 14..11 fault enables, default off
// [R11] pin two bit 15 on from reset
// [R12] pin two bit 10 overcurrent warning, default off
// [R13] pin one word absent on variant lacking pin
// [R14] pin two bit 3 sets alert polarity
// [R15] pin two bit 1 selects plain output
// [R16] pin two bit 0 sets plain output level
// [R17] alert drops when no enabled flag set
module apr_top #(
  parameter bit HAS_PIN_ONE = 1'b1
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus interface side, own clock
  input wire logic lk_clk,
  input wire logic lk_rstn,
  input wire apr_pkg::apr_lreq_t lk_req,
  output apr_pkg::apr_lans_t lk_ans,
  // status flag sources, system domain
  input wire apr_pkg::apr_flags_t flags,
  // multifunction pin one
  input wire logic pin_one_in,
  output apr_pkg::apr_pin_t pin_one,
  // multifunction pin two
  output apr_pkg::apr_pin_t pin_two,
  // conversion start pulse to the power monitor
  output logic conv_start
);
  import apr_pkg::*;

  // system domain state
  typedef struct packed {
    logic req_s1;          // write toggle, first sync stage
    logic req_s2;          // write toggle, second sync stage
    logic req_seen;        // last toggle taken, also the ack toggle
    logic [15:0] cfg1;     // pin one setup word
    logic [15:0] cfg2;     // pin two setup word
    logic conv_s1;         // pin one input, first sync stage
    logic conv_s2;         // pin one input, second sync stage
    logic conv_prev;       // previous synced level for edges
    logic conv;            // conversion pulse
    apr_pin_t p1;          // pin one driver
    apr_pin_t p2;          // pin two driver
  } apr_sys_t;

  // link domain state
  typedef struct packed {
    logic req_tog;         // flips once per accepted write
    logic ack_s1;          // ack toggle, first sync stage
    logic ack_s2;          // ack toggle, second sync stage
    logic hold_sel;        // held write targets pin two
    logic [15:0] hold_data;// held write word, stable while busy
    logic [15:0] mirror1;  // read copy of pin one word
    logic [15:0] mirror2;  // read copy of pin two word
    apr_lans_t ans;        // registered answer
  } apr_link_t;

  apr_sys_t s;
  apr_sys_t next_s;
  apr_link_t l;
  apr_link_t next_l;

  // flag and enable vectors
  logic [NUM_FLAGS-1:0] flag_vec;
  logic [NUM_FLAGS-1:0] en1;
  logic [NUM_FLAGS-1:0] en2;
  logic alert1;
  logic alert2;

  assign flag_vec = flags;
  assign en1 = s.cfg1[EN_HI:EN_LO]; // [R3] [R4]
  assign en2 = s.cfg2[EN_HI:EN_LO]; // [R10] [R11] [R12]
  // any enabled flag set, level follows flags both ways
  assign alert1 = |(flag_vec & en1); // [R5] [R17]
  assign alert2 = |(flag_vec & en2); // [R5] [R17]

  // link side: decode, answer, hold writes for crossing
  always_comb begin
    logic busy;
    logic hit1;
    logic hit2;
    busy = 1'b0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    next_l = l;
    // ack toggle back from system domain
    next_l.ack_s1 = s.req_seen;
    next_l.ack_s2 = l.ack_s1;
    // answer strobes last one cycle
    next_l.ans.ack = 1'b0;
    next_l.ans.nack = 1'b0;
    next_l.ans.rvalid = 1'b0;
    busy = l.req_tog != l.ack_s2;
    hit1 = (lk_req.cmd == CMD_PIN_ONE) && HAS_PIN_ONE; // [R1] [R13]
    hit2 = lk_req.cmd == CMD_PIN_TWO; // [R2]
    if (lk_req.wr) begin
      // write: refused while one is still crossing
      if (busy || !(hit1 || hit2)) begin
        next_l.ans.nack = 1'b1;
      end else if (hit2) begin
        next_l.mirror2 = lk_req.wdata & PIN_TWO_WMASK;
        next_l.hold_data = lk_req.wdata & PIN_TWO_WMASK;
        next_l.hold_sel = 1'b1;
        next_l.req_tog = ~l.req_tog;
        next_l.ans.ack = 1'b1;
      end else begin
        next_l.mirror1 = lk_req.wdata;
        next_l.hold_data = lk_req.wdata;
        next_l.hold_sel = 1'b0;
        next_l.req_tog = ~l.req_tog;
        next_l.ans.ack = 1'b1;
      end
    end else if (lk_req.rd) begin
      // read: answered from the local copy
      if (hit1) begin
        next_l.ans.rdata = l.mirror1;
        next_l.ans.rvalid = 1'b1;
      end else if (hit2) begin
        next_l.ans.rdata = l.mirror2;
        next_l.ans.rvalid = 1'b1;
      end else begin
        next_l.ans.nack = 1'b1;
      end
    end
    // synchronous reset of the link side
    if (!lk_rstn) begin
      next_l = '0;
      next_l.mirror1 = PIN_ONE_RST; // [R1]
      next_l.mirror2 = PIN_TWO_RST; // [R2]
    end
  end

  // link side register
  always_ff @(posedge lk_clk) begin
    l <= next_l;
  end

  assign lk_ans = l.ans;

  // system side: take writes, drive pins
  always_comb begin
    logic alvl1;
    logic alvl2;
    alvl1 = 1'b0;
    alvl2 = 1'b0;
    next_s = s;
    // write toggle sync, held word is stable by now
    next_s.req_s1 = l.req_tog;
    next_s.req_s2 = s.req_s1;
    if (s.req_s2 != s.req_seen) begin
      next_s.req_seen = s.req_s2;
      if (l.hold_sel) begin
        next_s.cfg2 = l.hold_data;
      end else begin
        next_s.cfg1 = l.hold_data;
      end
    end
    // pin one input sync and rising edge
    next_s.conv_s1 = pin_one_in;
    next_s.conv_s2 = s.conv_s1;
    next_s.conv_prev = s.conv_s2;
    next_s.conv = s.cfg1[CONV_BIT] && HAS_PIN_ONE
                  && s.conv_s2 && !s.conv_prev; // [R7]
    // alert level from polarity bit
    alvl1 = s.cfg1[POL_BIT] ? alert1 : ~alert1; // [R6]
    alvl2 = s.cfg2[POL_BIT] ? alert2 : ~alert2; // [R14]
    // pin one mode, input wins over plain output
    if (!HAS_PIN_ONE) begin
      next_s.p1 = '0; // [R13]
    end else if (s.cfg1[CONV_BIT]) begin
      next_s.p1.oe = 1'b0; // [R7]
      next_s.p1.out = 1'b0;
    end else if (s.cfg1[PLAIN_BIT]) begin
      next_s.p1.oe = 1'b1; // [R8]
      next_s.p1.out = s.cfg1[LEVEL_BIT]; // [R9]
    end else begin
      next_s.p1.oe = 1'b1;
      next_s.p1.out = alvl1; // [R5]
    end
    // pin two mode
    next_s.p2.oe = 1'b1;
    if (s.cfg2[PLAIN_BIT]) begin
      next_s.p2.out = s.cfg2[LEVEL_BIT]; // [R15] [R16]
    end else begin
      next_s.p2.out = alvl2; // [R15]
    end
    // synchronous reset of the system side
    if (!rstn) begin
      next_s = '0;
      next_s.cfg1 = PIN_ONE_RST; // [R1]
      next_s.cfg2 = PIN_TWO_RST; // [R2] [R11]
    end
  end

  // system side register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign pin_one = s.p1;
  assign pin_two = s.p2;
  assign conv_start = s.conv;

  // reset values of the setup words
  a_pin_one_reset: assert property (@(posedge clk) // [R1]
    !rstn |=> s.cfg1 == PIN_ONE_RST)
    else $error("pin one word not cleared by reset");
  a_pin_two_reset: assert property (@(posedge clk) // [R2]
    !rstn |=> s.cfg2 == PIN_TWO_RST)
    else $error("pin two word reset value wrong");

  // masked flags leave pin one alone
  a_masked_flag_quiet: assert property (@(posedge clk) // [R3]
    disable iff (!rstn)
    rstn && $past(rstn) && $stable(flag_vec & en1) && $stable(s.cfg1)
    |=> $stable(s.p1.out))
    else $error("pin one moved on a masked flag");

  // pin one alert follows enabled flags
  a_alert_one_set: assert property (@(posedge clk) // [R5]
    disable iff (!rstn)
    (HAS_PIN_ONE && s.cfg1[3:1] == 3'b000 && alert1)
    |=> (s.p1.out == 1'b0) && s.p1.oe)
    else $error("pin one alert not driven low");
  a_alert_one_idle: assert property (@(posedge clk) // [R17]
    disable iff (!rstn)
    (HAS_PIN_ONE && !s.cfg1[2] && !s.cfg1[1] && !alert1)
    |=> s.p1.out == !$past(s.cfg1[POL_BIT]))
    else $error("pin one alert not released");
  a_alert_one_high: assert property (@(posedge clk) // [R6]
    disable iff (!rstn)
    (HAS_PIN_ONE && s.cfg1[3:1] == 3'b100 && alert1)
    |=> s.p1.out)
    else $error("pin one alert not driven high");

  // conversion input floats the pin
  a_conv_input_oe: assert property (@(posedge clk) // [R7]
    disable iff (!rstn)
    s.cfg1[CONV_BIT] |=> !s.p1.oe)
    else $error("pin one driven while an input");

  // plain outputs copy their level bit
  a_plain_one_level: assert property (@(posedge clk) // [R9]
    disable iff (!rstn)
    (HAS_PIN_ONE && s.cfg1[2:1] == 2'b01)
    |=> s.p1.oe && (s.p1.out == $past(s.cfg1[LEVEL_BIT])))
    else $error("pin one plain level wrong");
  a_plain_two_level: assert property (@(posedge clk) // [R16]
    disable iff (!rstn)
    s.cfg2[PLAIN_BIT] |=> s.p2.out == $past(s.cfg2[LEVEL_BIT]))
    else $error("pin two plain level wrong");

  // pin two alert with its own polarity
  a_two_alert_mode: assert property (@(posedge clk) // [R14]
    disable iff (!rstn)
    (!s.cfg2[PLAIN_BIT] && alert2) |=> s.p2.out == $past(s.cfg2[3]))
    else $error("pin two alert level wrong");

  // pin two rests at its idle level when nothing enabled is set
  a_alert_two_idle: assert property (@(posedge clk) // [R17]
    disable iff (!rstn)
    (!s.cfg2[PLAIN_BIT] && !alert2)
    |=> s.p2.out == !$past(s.cfg2[POL_BIT]))
    else $error("pin two alert not released");

  // pin two is always driven once out of reset
  a_two_driven: assert property (@(posedge clk) // [R15]
    disable iff (!rstn)
    rstn |=> s.p2.oe)
    else $error("pin two not driven");

  // masked flags leave pin two alone
  a_two_masked_quiet: assert property (@(posedge clk) // [R10]
    disable iff (!rstn)
    rstn && $past(rstn) && $stable(flag_vec & en2) && $stable(s.cfg2)
    |=> $stable(s.p2.out))
    else $error("pin two moved on a masked flag");

  // conversion pulse lasts one cycle, only in input mode
  a_conv_one_cycle: assert property (@(posedge clk) // [R7]
    disable iff (!rstn)
    s.conv |=> !s.conv)
    else $error("conversion pulse longer than one cycle");
  a_conv_mode_only: assert property (@(posedge clk) // [R7]
    disable iff (!rstn)
    !s.cfg1[CONV_BIT] |=> !s.conv)
    else $error("conversion pulse outside input mode");

  // a read of pin two answers the stored word one cycle later
  a_read_two: assert property (@(posedge lk_clk) // [R2]
    disable iff (!lk_rstn)
    (lk_req.rd && !lk_req.wr && lk_req.cmd == CMD_PIN_TWO)
    |=> l.ans.rvalid && (l.ans.rdata == $past(l.mirror2)))
    else $error("pin two read answer wrong");

  // an accepted pin two write reaches its word within the crossing time
  a_write_lands: assert property (@(posedge lk_clk) // [R2]
    disable iff (!lk_rstn || !rstn)
    l.ans.ack && l.hold_sel |-> ##[1:8] s.cfg2 == l.mirror2)
    else $error("pin two write did not land");
endmodule : apr_top

/* dv/apr_host.sv */
`timescale 1ns/1ns
// word-port host: one pulse per request, answer one lk_clk later
module apr_host (
  // link clock
  input wire logic lk_clk,
  // request and answer
  output apr_pkg::apr_lreq_t lk_req,
  input wire apr_pkg::apr_lans_t lk_ans
);
  import apr_pkg::*;
  initial lk_req = '0;
  // one transfer, resp is {ack, nack, rvalid}
  task automatic xfer(input logic wr, input logic [7:0] cmd,
    input logic [15:0] d, output logic [2:0] resp, output logic [15:0] rd);
    @(negedge lk_clk);
    lk_req <= '{wr: wr, rd: ~wr, cmd: cmd, wdata: d};
    // taken at the rising edge between, answer stands one lk_clk
    @(negedge lk_clk);
    resp = {lk_ans.ack, lk_ans.nack, lk_ans.rvalid};
    rd = lk_ans.rdata;
    // released lines show the inverse, never the old word
    lk_req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: ~d};
    // a write must finish crossing before the next one
    if (wr) repeat (10) @(negedge lk_clk);
  endtask : xfer
endmodule : apr_host

/* dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import apr_pkg::*;
  logic clk, rstn, lk_clk, lk_rstn, tb_lvl, conv_start;
  apr_lreq_t lk_req;
  apr_lans_t lk_ans;
  apr_flags_t flags;
  apr_pin_t pin_one, pin_two;
  wire logic pin_one_in;
  logic [15:0] c1, c2; // model copies of the two words
  logic [31:0] seed;
  int mismatches, tests_run, n;
  // pin one wire: design drives it unless in input mode
  assign pin_one_in = pin_one.oe ? pin_one.out : tb_lvl;
  apr_top apr_top_inst (.clk(clk), .rstn(rstn), .lk_clk(lk_clk),
    .lk_rstn(lk_rstn), .lk_req(lk_req), .lk_ans(lk_ans), .flags(flags),
    .pin_one_in(pin_one_in), .pin_one(pin_one), .pin_two(pin_two),
    .conv_start(conv_start));
  apr_host apr_host_inst (.lk_clk(lk_clk), .lk_req(lk_req),
    .lk_ans(lk_ans));
  // system clock
  always #5 clk = ~clk;
  // link clock, offset phase
  initial begin
    lk_clk = 1'b0;
    #3;
    forever #6 lk_clk = ~lk_clk;
  end
  // random source
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected {out, oe} in alert or plain mode
  function automatic logic [1:0] model_pin(logic [15:0] cfg,
    logic [11:0] fl);
    if (cfg[1]) return {cfg[0], 1'b1};
    return {~((|(fl & cfg[15:4])) ^ cfg[3]), 1'b1};
  endfunction : model_pin
  task automatic check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d);
    logic [2:0] r;
    logic [15:0] x;
    apr_host_inst.xfer(1'b1, cmd, d, r, x);
    check("write_resp", {13'h0000, r}, 16'h0004);
  endtask : wr_word
  task automatic rd_word(input logic [7:0] cmd, input logic [15:0] e,
    input logic [2:0] er);
    logic [2:0] r;
    logic [15:0] x;
    apr_host_inst.xfer(1'b0, cmd, 16'h0000, r, x);
    check("read_resp", {13'h0000, r}, {13'h0000, er});
    check("read_word", x, e);
  endtask : rd_word
  // set flags, then compare both pins with the model; in input mode pin one oe is checked for zero instead
  task automatic pins_check(input logic [11:0] fl);
    logic [15:0] got1, got2, exp1, exp2;
    @(negedge clk);
    flags = fl;
    repeat (3) @(posedge clk);
    #1;
    got1 = {14'h0000, pin_one};
    exp1 = {14'h0000, model_pin(c1, fl)};
    got2 = {14'h0000, pin_two};
    exp2 = {14'h0000, model_pin(c2, fl)};
    if (c1[2]) check("pin_one_oe", {15'h0000, pin_one.oe}, 16'h0000);
    else if (c1[1]) check("pin_one_plain", got1, exp1);
    else check("pin_one_alert", got1, exp1);
    if (c2[1]) check("pin_two_plain", got2, exp2);
    else check("pin_two_alert", got2, exp2);
  endtask : pins_check
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // watchdog
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    lk_rstn = 1'b0;
    flags = '0;
    tb_lvl = 1'b0;
    seed = 32'hCB4C;
    c1 = PIN_ONE_RST;
    c2 = PIN_TWO_RST;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    lk_rstn = 1'b1;
    repeat (3) @(negedge clk);
    rd_word(CMD_PIN_ONE, 16'h0000, 3'b001);
    rd_word(CMD_PIN_TWO, 16'h8000, 3'b001);
    rd_word(8'hD7, 16'h8000, 3'b010);
    pins_check(12'h000);
    pins_check(12'h800);
    pins_check(12'h400);
    pins_check(12'h040);
    pins_check(12'h000);
    // random words and flag patterns
    repeat (16) begin
      seed = xs(seed);
      c1 = seed[15:0];
      c2 = seed[31:16] & PIN_TWO_WMASK;
      wr_word(CMD_PIN_ONE, c1);
      wr_word(CMD_PIN_TWO, seed[31:16]);
      rd_word(CMD_PIN_ONE, c1, 3'b001);
      rd_word(CMD_PIN_TWO, c2, 3'b001);
      repeat (4) begin
        seed = xs(seed);
        pins_check(seed[11:0] & seed[27:16]);
      end
    end
    // conversion trigger input
    c1 = 16'h0004;
    wr_word(CMD_PIN_ONE, c1);
    pins_check(12'hFFF);
    @(negedge clk);
    tb_lvl = 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (conv_start === 1'b1) n++;
    end
    check("conv_pulses", n[15:0], 16'h0001);
    tb_lvl = 1'b0;
    // second reset in mid-run, both words return to defaults
    @(negedge clk);
    rstn = 1'b0;
    lk_rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    lk_rstn = 1'b1;
    repeat (3) @(negedge clk);
    c1 = PIN_ONE_RST;
    c2 = PIN_TWO_RST;
    rd_word(CMD_PIN_ONE, c1, 3'b001);
    rd_word(CMD_PIN_TWO, c2, 3'b001);
    pins_check(12'h800);
    test_done;
  end
endmodule : tb_top
